// File: ssw_params.svh
// Constants of the serial write-multiple handler and its monitor registers.
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH
`define SSW_FC_WRITE    8'h10
`define SSW_FC_WR_ERR   8'h90
`define SSW_ERR_ADDR    8'h02
`define SSW_ERR_QTY     8'h03
`define SSW_MAX_QTY     16
`define SSW_CRC_INIT    16'hFFFF
`define SSW_CRC_POLY    16'hA001
`define SSW_HDR_LEN     8'h07
`define SSW_TRAIL_LEN   9'h009
`define SSW_OK_LEN      4'h6
`define SSW_ERR_LEN     4'h3
`define SSW_MON_FIRST   16'h0010
`define SSW_MON_OPER    16'h0011
`define SSW_MON_SETERR  16'h0012
`define SSW_MON_RSVD    16'h0013
`define SSW_MON_FAULT1  16'h0014
`define SSW_MON_LAST    16'h0015
`define SSW_ZERO16      16'h0000
`endif

// File: ssw_pkg.sv
// Types and the shared CRC step of the serial write-multiple handler.
`default_nettype none
`include "ssw_params.svh"
package ssw_pkg;
    typedef enum logic [2:0] {
        SSW_IDLE  = 3'b000,
        SSW_RECV  = 3'b001,
        SSW_CHECK = 3'b011,
        SSW_WRITE = 3'b010,
        SSW_REPLY = 3'b110,
        SSW_CRCHI = 3'b111,
        SSW_CRCLO = 3'b101
    } ssw_state_t;

    function automatic logic [15:0] ssw_crc_step(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `SSW_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// File: ssw_word_buf.sv
// Staging buffer for the data words of one write-multiple command.
`default_nettype none
module ssw_word_buf #(
    parameter int DW    = 16,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock
    input  wire logic          sys_clk,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read side
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // ssw_word_buf
`default_nettype wire

// File: ssw_top.sv
// Write-multiple command handler and read-only monitor registers of the drive.
`default_nettype none
`include "ssw_params.svh"
// Notes on behaviour
// - Function 10H writes consecutive registers from start.
// - Byte count must equal twice the quantity.
// - Success reply echoes address, function, start, quantity.
// - Failure reply sends 90H, error code, CRC.
// - Monitor registers 0010H to 0015H are read only.
// - Operator status: alarm, fault, programming, PC.
// - First fault word holds fifteen trips, bit 4 zero.
// - Second fault word: external faults and more.
// - Reads limited to sixteen words, upper byte first.
module ssw_top (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Station
    input  wire logic [7:0]  slave_addr,
    // Received bytes, frame end marked by the line-silence detector
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    input  wire logic        rx_frame_end,
    // Reply bytes
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    // Writes into the drive's register space
    output logic             reg_wr_en,
    output logic      [15:0] reg_wr_addr,
    output logic      [15:0] reg_wr_data,
    // Drive state
    input  wire logic [7:0]  drive_bits,
    input  wire logic        ref_via_link,
    input  wire logic        run_cmd_via_link,
    input  wire logic [3:0]  op_bits,
    input  wire logic [15:0] setting_error_num,
    input  wire logic [14:0] trip_flags,
    input  wire logic [4:0]  ext_fault,
    input  wire logic [7:0]  misc_fault,
    // Monitor read port
    input  wire logic [15:0] mon_rd_addr,
    output logic      [15:0] mon_rd_data
);
    // ==========================================================
    // Monitor registers
    logic [15:0] drive_status_r, op_status_r, set_err_r, fault1_r, fault2_r, mon_rd_data_r;
    logic [15:0] drive_status_nxt, op_status_nxt, set_err_nxt, fault1_nxt, fault2_nxt, mon_rd_nxt;

    always_comb begin
        drive_status_nxt = {run_cmd_via_link, ref_via_link, 6'h00, drive_bits};
        op_status_nxt    = {12'h000, op_bits};
        set_err_nxt      = setting_error_num;
        fault1_nxt       = {trip_flags[14:4], 1'b0, trip_flags[3:0]};
        fault2_nxt       = {1'b0, misc_fault, 2'b00, ext_fault};
        // Bits 15:8 go out first when the reader serialises a word.
        unique case (mon_rd_addr)
            `SSW_MON_FIRST:  mon_rd_nxt = drive_status_r;
            `SSW_MON_OPER:   mon_rd_nxt = op_status_r;
            `SSW_MON_SETERR: mon_rd_nxt = set_err_r;
            `SSW_MON_FAULT1: mon_rd_nxt = fault1_r;
            `SSW_MON_LAST:   mon_rd_nxt = fault2_r;
            default:         mon_rd_nxt = `SSW_ZERO16;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            drive_status_r <= `SSW_ZERO16;
            op_status_r    <= `SSW_ZERO16;
            set_err_r      <= `SSW_ZERO16;
            fault1_r       <= `SSW_ZERO16;
            fault2_r       <= `SSW_ZERO16;
            mon_rd_data_r  <= `SSW_ZERO16;
        end else begin
            drive_status_r <= drive_status_nxt;
            op_status_r    <= op_status_nxt;
            set_err_r      <= set_err_nxt;
            fault1_r       <= fault1_nxt;
            fault2_r       <= fault2_nxt;
            mon_rd_data_r  <= mon_rd_nxt;
        end
    end

    // ==========================================================
    // Command receive, check, write-out and reply
    ssw_pkg::ssw_state_t state_r, state_nxt;
    logic [7:0]  idx_r, idx_nxt, addr_r, addr_nxt, func_r, func_nxt, cnt_r, cnt_nxt;
    logic [7:0]  hi_r, hi_nxt, b1_r, b1_nxt, b2_r, b2_nxt, err_r, err_nxt;
    logic [7:0]  tx_data_r, tx_data_nxt, dpos;
    logic [15:0] start_r, start_nxt, qty_r, qty_nxt, crc_r, crc_nxt, d1_r, d1_nxt, d2_r, d2_nxt;
    logic [15:0] wr_addr_r, wr_addr_nxt, wr_data_r, wr_data_nxt, crc_base;
    logic [4:0]  wcnt_r, wcnt_nxt, widx_r, widx_nxt;
    logic [3:0]  tx_idx_r, tx_idx_nxt, rep_len;
    logic [16:0] last_reg;
    logic        tx_valid_r, tx_valid_nxt, pend_r, pend_nxt, wr_en_r, wr_en_nxt;
    logic        free, buf_we, in_rx;
    logic [3:0]  buf_rd_addr;
    logic [15:0] buf_rd_data;
    logic [7:0]  rep_byte;

    ssw_word_buf #(.DW(16), .DEPTH(`SSW_MAX_QTY), .AW(4)) u_buf (
        .sys_clk (sys_clk),
        .wr_en   (buf_we),
        .wr_addr (wcnt_r[3:0]),
        .wr_data ({hi_r, rx_data}),
        .rd_addr (buf_rd_addr),
        .rd_data (buf_rd_data)
    );

    always_comb begin
        state_nxt    = state_r;
        idx_nxt      = idx_r;
        addr_nxt     = addr_r;
        func_nxt     = func_r;
        cnt_nxt      = cnt_r;
        hi_nxt       = hi_r;
        b1_nxt       = b1_r;
        b2_nxt       = b2_r;
        err_nxt      = err_r;
        start_nxt    = start_r;
        qty_nxt      = qty_r;
        crc_nxt      = crc_r;
        d1_nxt       = d1_r;
        d2_nxt       = d2_r;
        wcnt_nxt     = wcnt_r;
        widx_nxt     = widx_r;
        tx_idx_nxt   = tx_idx_r;
        tx_data_nxt  = tx_data_r;
        tx_valid_nxt = tx_valid_r;
        pend_nxt     = 1'b0;
        wr_en_nxt    = pend_r;
        wr_data_nxt  = pend_r ? buf_rd_data : wr_data_r;
        wr_addr_nxt  = start_r + {11'h000, widx_r - 5'h01};
        buf_we       = 1'b0;
        buf_rd_addr  = widx_r[3:0];
        in_rx        = (state_r == ssw_pkg::SSW_IDLE) || (state_r == ssw_pkg::SSW_RECV);
        crc_base     = (state_r == ssw_pkg::SSW_IDLE) ? `SSW_CRC_INIT : crc_r;
        dpos         = idx_r - `SSW_HDR_LEN;
        last_reg     = {1'b0, start_r} + {1'b0, qty_r} - 17'h00001;
        free         = !tx_valid_r || tx_ready;
        rep_len      = (err_r != 8'h00) ? `SSW_ERR_LEN : `SSW_OK_LEN;
        unique case (tx_idx_r)
            4'h0:    rep_byte = addr_r;
            4'h1:    rep_byte = (err_r != 8'h00) ? `SSW_FC_WR_ERR : `SSW_FC_WRITE;
            4'h2:    rep_byte = (err_r != 8'h00) ? err_r : start_r[15:8];
            4'h3:    rep_byte = start_r[7:0];
            4'h4:    rep_byte = qty_r[15:8];
            default: rep_byte = qty_r[7:0];
        endcase

        if (in_rx && rx_valid) begin
            state_nxt = ssw_pkg::SSW_RECV;
            crc_nxt   = ssw_pkg::ssw_crc_step(crc_base, rx_data);
            d1_nxt    = crc_base;
            d2_nxt    = d1_r;
            b1_nxt    = rx_data;
            b2_nxt    = b1_r;
            idx_nxt   = (idx_r == 8'hFF) ? idx_r : idx_r + 8'h01;
            unique case (idx_r)
                8'h00: addr_nxt = rx_data;
                8'h01: func_nxt = rx_data;
                8'h02: start_nxt[15:8] = rx_data;
                8'h03: start_nxt[7:0] = rx_data;
                8'h04: qty_nxt[15:8] = rx_data;
                8'h05: qty_nxt[7:0] = rx_data;
                8'h06: cnt_nxt = rx_data;
                default: begin
                    if (dpos < cnt_r) begin
                        // Upper byte arrives first and waits for its lower half.
                        if (!dpos[0]) begin
                            hi_nxt = rx_data;
                        end else if (wcnt_r < 5'(`SSW_MAX_QTY)) begin
                            buf_we   = 1'b1;
                            wcnt_nxt = wcnt_r + 5'h01;
                        end
                    end
                end
            endcase
        end else if (state_r == ssw_pkg::SSW_RECV && rx_frame_end) begin
            state_nxt = ssw_pkg::SSW_CHECK;
        end

        unique case (state_r)
            ssw_pkg::SSW_CHECK: begin
                // Corrupt frames and frames for other stations get no reply at all.
                // The check word travels low byte first, so the earlier byte holds bits 7:0.
                if (idx_r < 8'h04 || {b1_r, b2_r} != d2_r || addr_r != slave_addr || func_r != `SSW_FC_WRITE) begin
                    state_nxt = ssw_pkg::SSW_IDLE;
                end else begin
                    if (start_r <= `SSW_MON_LAST && last_reg >= {1'b0, `SSW_MON_FIRST}) begin
                        err_nxt = `SSW_ERR_ADDR;
                    end else if (qty_r == 16'h0000 || qty_r > 16'(`SSW_MAX_QTY)
                                 || {8'h00, cnt_r} != {qty_r[14:0], 1'b0}
                                 || {1'b0, idx_r} != `SSW_TRAIL_LEN + {1'b0, cnt_r}) begin
                        err_nxt = `SSW_ERR_QTY;
                    end
                    state_nxt = (err_nxt != 8'h00) ? ssw_pkg::SSW_REPLY : ssw_pkg::SSW_WRITE;
                    crc_nxt   = `SSW_CRC_INIT;
                end
            end
            ssw_pkg::SSW_WRITE: begin
                if ({11'h000, widx_r} < qty_r) begin
                    pend_nxt = 1'b1;
                    widx_nxt = widx_r + 5'h01;
                end else if (!pend_r) begin
                    state_nxt = ssw_pkg::SSW_REPLY;
                end
            end
            ssw_pkg::SSW_REPLY, ssw_pkg::SSW_CRCHI, ssw_pkg::SSW_CRCLO: begin
                if (free) begin
                    tx_valid_nxt = 1'b1;
                    if (state_r == ssw_pkg::SSW_REPLY && tx_idx_r < rep_len) begin
                        tx_data_nxt = rep_byte;
                        crc_nxt     = ssw_pkg::ssw_crc_step(crc_r, rep_byte);
                        tx_idx_nxt  = tx_idx_r + 4'h1;
                    end else if (state_r == ssw_pkg::SSW_REPLY) begin
                        tx_data_nxt = crc_r[7:0];
                        state_nxt   = ssw_pkg::SSW_CRCHI;
                    end else if (state_r == ssw_pkg::SSW_CRCHI) begin
                        tx_data_nxt = crc_r[15:8];
                        state_nxt   = ssw_pkg::SSW_CRCLO;
                    end else begin
                        tx_valid_nxt = 1'b0;
                        state_nxt    = ssw_pkg::SSW_IDLE;
                    end
                end
            end
            default: ;
        endcase

        if (state_r != ssw_pkg::SSW_IDLE && state_nxt == ssw_pkg::SSW_IDLE) begin
            idx_nxt    = 8'h00;
            wcnt_nxt   = 5'h00;
            widx_nxt   = 5'h00;
            tx_idx_nxt = 4'h0;
            err_nxt    = 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_r    <= ssw_pkg::SSW_IDLE;
            idx_r      <= 8'h00;
            addr_r     <= 8'h00;
            func_r     <= 8'h00;
            cnt_r      <= 8'h00;
            hi_r       <= 8'h00;
            b1_r       <= 8'h00;
            b2_r       <= 8'h00;
            err_r      <= 8'h00;
            start_r    <= `SSW_ZERO16;
            qty_r      <= `SSW_ZERO16;
            crc_r      <= `SSW_CRC_INIT;
            d1_r       <= `SSW_CRC_INIT;
            d2_r       <= `SSW_CRC_INIT;
            wcnt_r     <= 5'h00;
            widx_r     <= 5'h00;
            tx_idx_r   <= 4'h0;
            tx_data_r  <= 8'h00;
            tx_valid_r <= 1'b0;
            pend_r     <= 1'b0;
            wr_en_r    <= 1'b0;
            wr_addr_r  <= `SSW_ZERO16;
            wr_data_r  <= `SSW_ZERO16;
        end else begin
            state_r    <= state_nxt;
            idx_r      <= idx_nxt;
            addr_r     <= addr_nxt;
            func_r     <= func_nxt;
            cnt_r      <= cnt_nxt;
            hi_r       <= hi_nxt;
            b1_r       <= b1_nxt;
            b2_r       <= b2_nxt;
            err_r      <= err_nxt;
            start_r    <= start_nxt;
            qty_r      <= qty_nxt;
            crc_r      <= crc_nxt;
            d1_r       <= d1_nxt;
            d2_r       <= d2_nxt;
            wcnt_r     <= wcnt_nxt;
            widx_r     <= widx_nxt;
            tx_idx_r   <= tx_idx_nxt;
            tx_data_r  <= tx_data_nxt;
            tx_valid_r <= tx_valid_nxt;
            pend_r     <= pend_nxt;
            wr_en_r    <= wr_en_nxt;
            wr_addr_r  <= wr_addr_nxt;
            wr_data_r  <= wr_data_nxt;
        end
    end

    assign tx_data     = tx_data_r;
    assign tx_valid    = tx_valid_r;
    assign reg_wr_en   = wr_en_r;
    assign reg_wr_addr = wr_addr_r;
    assign reg_wr_data = wr_data_r;
    assign mon_rd_data = mon_rd_data_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_write_ascend: assert property (wr_en_r && $past(wr_en_r) |-> wr_addr_r == $past(wr_addr_r) + 16'h0001)
        else $error("write addresses not consecutive");
    a_write_range: assert property (wr_en_r |-> (wr_addr_r - start_r) < qty_r)
        else $error("write outside commanded range");
    a_count_match: assert property ($past(state_r == ssw_pkg::SSW_CHECK) && state_r == ssw_pkg::SSW_WRITE
        |-> {8'h00, cnt_r} == {qty_r[14:0], 1'b0})
        else $error("write started with bad byte count");
    a_reply_addr: assert property (state_r == ssw_pkg::SSW_REPLY && tx_valid_r && tx_idx_r == 4'h1
        |-> tx_data_r == addr_r)
        else $error("reply does not open with station address");
    a_reply_func: assert property (state_r == ssw_pkg::SSW_REPLY && tx_valid_r && tx_idx_r == 4'h2
        |-> tx_data_r == ((err_r == 8'h00) ? `SSW_FC_WRITE : `SSW_FC_WR_ERR))
        else $error("reply function code wrong");
    a_error_len: assert property (state_r == ssw_pkg::SSW_CRCHI && err_r != 8'h00 |-> tx_idx_r == 4'h3)
        else $error("error reply length wrong");
    a_mon_guard: assert property (wr_en_r |-> wr_addr_r < `SSW_MON_FIRST || wr_addr_r > `SSW_MON_LAST)
        else $error("monitor register written");
    a_status_bits: assert property (drive_status_r[13:8] == 6'h00
        && drive_status_r[15] == $past(run_cmd_via_link))
        else $error("drive status layout wrong");
    a_oper_bits: assert property (op_status_r[15:4] == 12'h000 && op_status_r[3] == $past(op_bits[3]))
        else $error("operator status layout wrong");
    a_fault1_gap: assert property (fault1_r[4] == 1'b0 && fault1_r[15] == $past(trip_flags[14]))
        else $error("first fault word layout wrong");
    a_fault2_gap: assert property (fault2_r[6:5] == 2'b00 && !fault2_r[15]
        && fault2_r[14] == $past(misc_fault[7]))
        else $error("second fault word layout wrong");
    a_read_word: assert property (mon_rd_addr == `SSW_MON_FIRST ##1 1 |-> mon_rd_data_r == $past(drive_status_r))
        else $error("monitor read data wrong");

    c_write_ok: cover property (state_r == ssw_pkg::SSW_WRITE ##[1:40] state_r == ssw_pkg::SSW_CRCLO);
    c_error_reply: cover property (state_r == ssw_pkg::SSW_CRCHI && err_r == `SSW_ERR_ADDR);
    c_frame_drop: cover property (state_r == ssw_pkg::SSW_CHECK ##1 state_r == ssw_pkg::SSW_IDLE);
endmodule // ssw_top
`default_nettype wire

// File: ssw_master.sv
// Behavioural serial bus master that sends write frames and sinks replies.
`default_nettype none
module ssw_master (
    // Clock
    input  wire logic       sys_clk,
    // Request bytes
    output var  logic [7:0] rx_data,
    output var  logic       rx_valid,
    output var  logic       rx_frame_end,
    // Reply bytes
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var  logic       tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] ssw_bytes_t[$];
    typedef logic [15:0] ssw_words_t[$];
    logic [7:0] rsp[$];
    bit         slow;
    int         ph;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_frame_end = 1'b0;
        tx_ready = 1'b0;
        slow = 1'b0;
        ph = 0;
    end
    // A slow sink holds ready low for two of every three cycles.
    always @(posedge sys_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) rsp.push_back(tx_data);
        ph <= ph + 1;
        tx_ready <= #1 !slow || (ph % 3 == 0);
    end
    function automatic logic [15:0] crc16(input ssw_bytes_t b);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction
    // The line carries the inverse of the last byte between frames.
    task automatic write(input logic [7:0] st, input logic [15:0] sa, input ssw_words_t w,
                         input int adj, input bit bad);
        ssw_bytes_t  f;
        logic [15:0] q;
        logic [15:0] c;
        q = 16'(w.size());
        f = '{st, 8'h10, sa[15:8], sa[7:0], q[15:8], q[7:0], 8'(2 * w.size() + adj)};
        foreach (w[i]) begin
            f.push_back(w[i][15:8]);
            f.push_back(w[i][7:0]);
        end
        c = crc16(f) ^ {15'h0, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(posedge sys_clk);
            #1;
            rx_data = f[i];
            rx_valid = 1'b1;
        end
        @(posedge sys_clk);
        #1;
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        rx_frame_end = 1'b1;
        @(posedge sys_clk);
        #1;
        rx_frame_end = 1'b0;
    endtask
endmodule // ssw_master
`default_nettype wire

// File: tb_serial_slave_write_and_monitor.sv
// Self-checking bench of the write-multiple handler and the monitor words.
`default_nettype none
module tb_serial_slave_write_and_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] ssw_bytes_t[$];
    typedef logic [15:0] ssw_words_t[$];
    logic        sys_clk;
    logic        resetn;
    logic [7:0]  slave_addr;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_frame_end;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic        reg_wr_en;
    logic [15:0] reg_wr_addr;
    logic [15:0] reg_wr_data;
    logic [7:0]  drive_bits;
    logic        ref_via_link;
    logic        run_cmd_via_link;
    logic [3:0]  op_bits;
    logic [15:0] setting_error_num;
    logic [14:0] trip_flags;
    logic [4:0]  ext_fault;
    logic [7:0]  misc_fault;
    logic [15:0] mon_rd_addr;
    logic [15:0] mon_rd_data;
    logic [15:0] wa[$];
    logic [15:0] wd[$];
    int          num_errors = 0;
    int          checked = 0;
    ssw_top dut (.sys_clk, .resetn, .slave_addr, .rx_data, .rx_valid, .rx_frame_end, .tx_data, .tx_valid,
                 .tx_ready, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .drive_bits, .ref_via_link,
                 .run_cmd_via_link, .op_bits, .setting_error_num, .trip_flags, .ext_fault, .misc_fault,
                 .mon_rd_addr, .mon_rd_data);
    ssw_master m (.sys_clk, .rx_data, .rx_valid, .rx_frame_end, .tx_data, .tx_valid, .tx_ready);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (reg_wr_en === 1'b1) begin
        wa.push_back(reg_wr_addr);
        wd.push_back(reg_wr_data);
    end
    // ==========================================================
    // Shared checks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic ssw_bytes_t with_crc(input ssw_bytes_t b);
        logic [15:0] c;
        c = m.crc16(b);
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        return b;
    endfunction
    // The extra wait after the last byte catches replies that run long.
    task automatic expect_reply(input ssw_bytes_t e);
        ssw_bytes_t r;
        for (int i = 0; i < 400 && m.rsp.size() < e.size(); i++) @(posedge sys_clk);
        repeat (30) @(posedge sys_clk);
        r = m.rsp;
        m.rsp.delete();
        check("reply length", 16'(r.size()), 16'(e.size()));
        foreach (e[i]) if (i < r.size()) check("reply byte", {8'h00, r[i]}, {8'h00, e[i]});
    endtask
    task automatic expect_writes(input logic [15:0] sa, input ssw_words_t w);
        check("write count", 16'(wa.size()), 16'(w.size()));
        foreach (w[i]) if (i < wa.size()) begin
            check("write addr", wa[i], sa + 16'(i));
            check("write data", wd[i], w[i]);
        end
        wa.delete();
        wd.delete();
    endtask
    task automatic refuse(input logic [15:0] sa, input ssw_words_t w, input int adj, input logic [7:0] code);
        m.write(8'h01, sa, w, adj, 1'b0);
        expect_reply(with_crc('{8'h01, 8'h90, code}));
        expect_writes(sa, '{});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_example();
        m.slow = 1'b1;
        m.write(8'h01, 16'h0001, '{16'h0001, 16'h0258}, 0, 1'b0);
        expect_reply('{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h10, 8'h08});
        expect_writes(16'h0001, '{16'h0001, 16'h0258});
        m.slow = 1'b0;
    endtask
    task automatic t_full_block();
        ssw_words_t w;
        for (int k = 0; k < 16; k++) w.push_back(16'hA500 + 16'(k));
        m.write(8'h01, 16'h0100, w, 0, 1'b0);
        expect_reply(with_crc('{8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h10}));
        expect_writes(16'h0100, w);
    endtask
    task automatic t_refusals();
        ssw_words_t w;
        for (int k = 0; k < 17; k++) w.push_back(16'h3C00 + 16'(k));
        m.write(8'h01, 16'h0010, '{16'h1234}, 0, 1'b0);
        expect_reply('{8'h01, 8'h90, 8'h02, 8'hCD, 8'hC1});
        expect_writes(16'h0010, '{});
        refuse(16'h000F, w[0:1], 0, 8'h02);
        refuse(16'h0015, w[0:0], 0, 8'h02);
        refuse(16'h0020, w[0:1], 1, 8'h03);
        refuse(16'h0020, '{}, 0, 8'h03);
        refuse(16'h0020, w, 0, 8'h03);
    endtask
    task automatic t_silent();
        m.write(8'h02, 16'h0001, '{16'h0001}, 0, 1'b0);
        expect_reply('{});
        m.write(8'h01, 16'h0001, '{16'h0001}, 0, 1'b1);
        expect_reply('{});
        expect_writes(16'h0001, '{});
    endtask
    task automatic t_monitor();
        logic [15:0] e[7];
        for (int p = 0; p < 2; p++) begin
            drive_bits = p ? 8'hFF : 8'h5A;
            {run_cmd_via_link, ref_via_link} = p ? 2'b11 : 2'b10;
            op_bits = p ? 4'hF : 4'h9;
            setting_error_num = p ? 16'hFFFF : 16'h0C3A;
            trip_flags = p ? 15'h7FFF : 15'h2B3C;
            ext_fault = p ? 5'h1F : 5'h15;
            misc_fault = p ? 8'hFF : 8'hA6;
            e = '{{run_cmd_via_link, ref_via_link, 6'h00, drive_bits}, {12'h000, op_bits}, setting_error_num,
                  16'h0000, {trip_flags[14:4], 1'b0, trip_flags[3:0]}, {1'b0, misc_fault, 2'b00, ext_fault},
                  16'h0000};
            for (int a = 0; a < 7; a++) begin
                mon_rd_addr = 16'h0010 + 16'(a);
                repeat (3) @(posedge sys_clk);
                #1;
                check("monitor word", mon_rd_data, e[a]);
            end
        end
    endtask
    // ==========================================================
    // Sequence and verdict
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        resetn = 1'b0;
        slave_addr = 8'h01;
        drive_bits = 8'h00;
        {run_cmd_via_link, ref_via_link} = 2'b00;
        op_bits = 4'h0;
        setting_error_num = 16'h0000;
        trip_flags = 15'h0;
        ext_fault = 5'h00;
        misc_fault = 8'h00;
        mon_rd_addr = 16'h0000;
        repeat (4) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        check("reply valid idle", {15'h0, tx_valid}, 16'h0000);
        check("monitor after reset", mon_rd_data, 16'h0000);
        t_example();
        t_full_block();
        t_refusals();
        t_silent();
        @(posedge sys_clk);
        #1;
        t_monitor();
        tally_and_finish();
    end
endmodule // tb_serial_slave_write_and_monitor
`default_nettype wire
